// [src/adcinj_pkg.sv]
// Shared constants and types for the converter channel-injection path.
// Assumes one system clock and an asynchronous active-high reset.
// Function
// - New injection on unread result stalls converter
// - Software reads injected result once per injection
// - Clearing then setting wait-for-read releases stall
// - Injection converts one channel, mode untouched
// - Injections serviced during continuous or scan
// - Injection needs wait-for-read mode enabled; the code also injects with it off, overwriting an unread result
// - Injected result goes to injected result register
// - Injection completion sets flag and raises irq
// - Occupied temporary buffer holds off next conversion
// - Temporary buffer holds standard or injected result
// - Injected value kept buffered until earlier read
// - Read moves buffer and raises fresh irq
// - Compare event or software may trigger injection
// - Event transfer engine may collect injected results
// - Never let two injections precede result read
package adcinj_pkg;
   localparam int unsigned ADCINJ_DATA_W = 10;
   localparam int unsigned ADCINJ_CHAN_W = 5;
   localparam int unsigned ADCINJ_FIFO_DEPTH = 16;
   // Conversion time in ns and the derived cycle count at 40 MHz
   localparam int unsigned ADCINJ_CLK_NS = 25;
   localparam int unsigned ADCINJ_CONV_NS = 3000;
   localparam int unsigned ADCINJ_CONV_CYC = (ADCINJ_CONV_NS + ADCINJ_CLK_NS - 1) / ADCINJ_CLK_NS;
   localparam int unsigned ADCINJ_CNT_W = 8;
   localparam logic [ADCINJ_CNT_W-1:0] ADCINJ_CONV_LAST = ADCINJ_CNT_W'(ADCINJ_CONV_CYC - 1);
   localparam logic [ADCINJ_DATA_W-1:0] ADCINJ_RESULT_RST = 10'h000;
   localparam logic [ADCINJ_CHAN_W-1:0] ADCINJ_CHAN_RST = 5'h00;

   typedef enum logic [1:0] {
      ADCINJ_MODE_SINGLE,
      ADCINJ_MODE_CONT,
      ADCINJ_MODE_SCAN,
      ADCINJ_MODE_CONT_SCAN
   } adcinj_mode_e;

   typedef enum {
      ADCINJ_ST_IDLE,
      ADCINJ_ST_CONV,
      ADCINJ_ST_DONE
   } adcinj_state_e;
endpackage

// [src/adcinj_if.sv]
// Connection between the converter end and the result reader end.
// Assumes both ends share mclk_in.
`timescale 1ns/1ps
interface adcinj_if;
   import adcinj_pkg::*;
   logic [ADCINJ_DATA_W-1:0] std_data;
   logic std_valid;
   logic std_ready;
   logic [ADCINJ_DATA_W-1:0] inj_data;
   logic injection_done_irq;
   logic inj_read;
   logic soft_inject;
   logic trigger_compare_channel;
   logic [ADCINJ_CHAN_W-1:0] inj_channel;
   logic wait_read_en;

   modport dev (
      output std_data, std_valid, inj_data, injection_done_irq,
      input std_ready, inj_read, soft_inject, trigger_compare_channel, inj_channel,
      wait_read_en
   );
   modport host (
      input std_data, std_valid, inj_data, injection_done_irq,
      output std_ready, inj_read, soft_inject, trigger_compare_channel, inj_channel,
      wait_read_en
   );
endinterface

// [src/adcinj_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and asynchronous active-high reset.
`timescale 1ns/1ps
module adcinj_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } adcinj_fifo_s;

   adcinj_fifo_s st_q, st_d;
   logic push, pop;

   assign in_ready_out = (st_q.cnt != (AW+1)'(DEPTH));
   assign out_valid_out = (st_q.cnt != '0);
   assign out_data_out = st_q.mem[st_q.rd];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.mem[st_q.wr] = in_data_in;
         st_d.wr = (st_q.wr == AW'(DEPTH-1)) ? '0 : st_q.wr + 1'b1;
      end
      if (pop) begin
         st_d.rd = (st_q.rd == AW'(DEPTH-1)) ? '0 : st_q.rd + 1'b1;
      end
      st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// [src/adcinj_dev.sv]
// Converter end: standard sequence, channel injection, temporary buffer.
// Assumes the analog sample arrives as a same-clock word on sample_in.
`timescale 1ns/1ps
module adcinj_dev
   import adcinj_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Link to reader
   adcinj_if.dev lnk,
   // Converter setup
   input wire logic [1:0] mode_in,
   input wire logic [ADCINJ_CHAN_W-1:0] std_channel_in,
   input wire logic start_in,
   input wire logic [ADCINJ_DATA_W-1:0] sample_in,
   // Status
   output logic busy_out,
   output logic stalled_out,
   output logic injection_done_flag_out,
   output logic [ADCINJ_CHAN_W-1:0] conv_channel_out
);
   // ====================================================================
   // State
   typedef struct packed {
      adcinj_state_e st;
      logic [ADCINJ_CNT_W-1:0] cnt;
      logic cur_inj;
      logic [ADCINJ_CHAN_W-1:0] chan;
      logic [ADCINJ_CHAN_W-1:0] std_chan;
      logic [ADCINJ_CHAN_W-1:0] scan_top;
      logic running;
      logic inj_pend;
      logic [ADCINJ_DATA_W-1:0] inj_res;
      logic inj_unread;
      logic [ADCINJ_DATA_W-1:0] tmp;
      logic tmp_full;
      logic tmp_inj;
      logic wr_was_off;
      logic flag;
      logic irq;
      logic [ADCINJ_DATA_W-1:0] std_wr;
      logic std_wr_v;
   } adcinj_dev_s;

   adcinj_dev_s q, d;
   logic fifo_ready;
   logic std_slot_free;
   logic conv_end;

   // ====================================================================
   // Standard result FIFO
   adcinj_fifo #(.WIDTH(ADCINJ_DATA_W), .DEPTH(ADCINJ_FIFO_DEPTH)) u_fifo (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .in_valid_in(q.std_wr_v),
      .in_ready_out(fifo_ready),
      .in_data_in(q.std_wr),
      .out_valid_out(lnk.std_valid),
      .out_ready_in(lnk.std_ready),
      .out_data_out(lnk.std_data)
   );

   // ====================================================================
   // Helpers
   // Slot for a standard result: empty, or its word leaves this cycle
   assign std_slot_free = !q.std_wr_v || fifo_ready;
   // Last counted cycle of a conversion
   assign conv_end = (q.st == ADCINJ_ST_CONV) && (q.cnt == ADCINJ_CONV_LAST);

   // Next standard channel; a continuous scan starts again at its top channel
   function automatic logic [ADCINJ_CHAN_W-1:0] next_chan(
      input logic [1:0] m, input logic [ADCINJ_CHAN_W-1:0] c,
      input logic [ADCINJ_CHAN_W-1:0] top);
      if (!m[1]) begin
         next_chan = c;
      end else if (c != '0) begin
         next_chan = c - 1'b1;
      end else if (m[0]) begin
         next_chan = top;
      end else begin
         next_chan = '0;
      end
   endfunction

   // ====================================================================
   // Next state
   always_comb begin
      d = q;
      d.irq = 1'b0;
      // Remembers a low level so that only a real off-then-on releases
      d.wr_was_off = !lnk.wait_read_en;
      if (q.std_wr_v && fifo_ready) begin
         d.std_wr_v = 1'b0;
      end
      // Latched once; a repeat while pending is absorbed
      if (lnk.soft_inject || lnk.trigger_compare_channel) begin
         d.inj_pend = 1'b1;
      end
      // A read frees the result register and refills it from the buffer when that holds an injected result
      if (lnk.inj_read && q.inj_unread) begin
         d.inj_unread = 1'b0;
         if (q.tmp_full && q.tmp_inj) begin
            d.inj_res = q.tmp;
            d.tmp_full = 1'b0;
            d.inj_unread = 1'b1;
            d.flag = 1'b1;
            d.irq = 1'b1;
         end
      end
      // Buffered standard result drains when the FIFO slot is free
      if (q.tmp_full && !q.tmp_inj && std_slot_free && !d.std_wr_v) begin
         d.std_wr = q.tmp;
         d.std_wr_v = 1'b1;
         d.tmp_full = 1'b0;
      end
      // Toggling wait-for-read off then on drops a stuck buffer
      if (lnk.wait_read_en && q.wr_was_off) begin
         d.tmp_full = 1'b0;
      end
      unique case (q.st)
         ADCINJ_ST_IDLE: begin
            // No new conversion while the buffer is occupied
            if (!q.tmp_full) begin
               if (q.inj_pend) begin
                  // Injection leaves mode and std channel untouched
                  d.st = ADCINJ_ST_CONV;
                  d.cur_inj = 1'b1;
                  d.chan = lnk.inj_channel;
                  d.cnt = '0;
                  d.inj_pend = lnk.soft_inject || lnk.trigger_compare_channel;
               end else if (q.running) begin
                  d.st = ADCINJ_ST_CONV;
                  d.cur_inj = 1'b0;
                  d.chan = q.std_chan;
                  d.cnt = '0;
               end
            end
         end
         ADCINJ_ST_CONV: begin
            d.cnt = q.cnt + 1'b1;
            if (conv_end) begin
               d.st = ADCINJ_ST_DONE;
            end
         end
         ADCINJ_ST_DONE: begin
            d.st = ADCINJ_ST_IDLE;
            if (q.cur_inj) begin
               if (d.inj_unread && lnk.wait_read_en) begin
                  // Held in the buffer until the earlier result is read
                  d.tmp = sample_in;
                  d.tmp_full = 1'b1;
                  d.tmp_inj = 1'b1;
               end else begin
                  d.inj_res = sample_in;
                  d.inj_unread = 1'b1;
                  d.flag = 1'b1;
                  d.irq = 1'b1;
               end
            end else begin
               if (std_slot_free && !d.std_wr_v) begin
                  d.std_wr = sample_in;
                  d.std_wr_v = 1'b1;
               end else begin
                  // FIFO full: the result waits here and stalls the converter
                  d.tmp = sample_in;
                  d.tmp_full = 1'b1;
                  d.tmp_inj = 1'b0;
               end
               d.std_chan = next_chan(mode_in, q.std_chan, q.scan_top);
               // Single conversion and plain scan stop after their last channel
               if (mode_in == 2'(ADCINJ_MODE_SINGLE) ||
                   (mode_in == 2'(ADCINJ_MODE_SCAN) && q.std_chan == '0)) begin
                  d.running = 1'b0;
               end
            end
         end
      endcase
      // A start pulse wins over a sequence ending in the same cycle
      if (start_in) begin
         d.running = 1'b1;
         d.std_chan = std_channel_in;
         d.scan_top = std_channel_in;
      end
   end

   // ====================================================================
   // Link outputs
   // Injected result and its completion pulse
   assign lnk.inj_data = q.inj_res;
   assign lnk.injection_done_irq = q.irq;

   // ====================================================================
   // Registers
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '0;
         busy_out <= 1'b0;
         stalled_out <= 1'b0;
         injection_done_flag_out <= 1'b0;
         conv_channel_out <= ADCINJ_CHAN_RST;
      end else begin
         q <= d;
         busy_out <= d.st != ADCINJ_ST_IDLE;
         stalled_out <= d.tmp_full;
         injection_done_flag_out <= d.flag;
         conv_channel_out <= d.chan;
      end
   end
endmodule

// [src/adcinj_host.sv]
// Reader end: triggers injections, collects results on completion.
// Assumes the user side issues single-cycle trigger pulses.
`timescale 1ns/1ps
module adcinj_host
   import adcinj_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Link to converter
   adcinj_if.host lnk,
   // User control
   input wire logic soft_req_in,
   input wire logic compare_evt_in,
   input wire logic [ADCINJ_CHAN_W-1:0] channel_in,
   input wire logic wait_read_en_in,
   input wire logic std_take_in,
   // Results
   output logic [ADCINJ_DATA_W-1:0] inj_result_out,
   output logic inj_result_valid_out,
   output logic [ADCINJ_DATA_W-1:0] std_result_out,
   output logic std_result_valid_out
);
   typedef struct packed {
      logic rd_pend;
      logic rd;
   } adcinj_host_s;

   adcinj_host_s q, d;

   assign lnk.soft_inject = soft_req_in;
   assign lnk.trigger_compare_channel = compare_evt_in;
   assign lnk.inj_channel = channel_in;
   assign lnk.wait_read_en = wait_read_en_in;
   assign lnk.std_ready = std_take_in;
   assign lnk.inj_read = q.rd;

   // ====================================================================
   // Read sequencing
   // Each completion pulse, a refill included, gets one read
   always_comb begin
      d = q;
      d.rd = 1'b0;
      if (lnk.injection_done_irq) begin
         d.rd_pend = 1'b1;
      end else if (q.rd_pend) begin
         d.rd = 1'b1;
         d.rd_pend = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '0;
         inj_result_out <= ADCINJ_RESULT_RST;
         inj_result_valid_out <= 1'b0;
         std_result_out <= ADCINJ_RESULT_RST;
         std_result_valid_out <= 1'b0;
      end else begin
         q <= d;
         inj_result_valid_out <= d.rd;
         if (d.rd) begin
            inj_result_out <= lnk.inj_data;
         end
         std_result_valid_out <= lnk.std_valid && std_take_in;
         if (lnk.std_valid && std_take_in) begin
            std_result_out <= lnk.std_data;
         end
      end
   end
endmodule

// [dv/adcinj_sva.sv]
// Checker on the converter to reader link.
// Assumes the signals of one adcinj_if, the shared clock and its reset.
`timescale 1ns/1ps
module adcinj_sva
   import adcinj_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Link signals
   input wire logic [ADCINJ_DATA_W-1:0] std_data,
   input wire logic std_valid,
   input wire logic std_ready,
   input wire logic [ADCINJ_DATA_W-1:0] inj_data,
   input wire logic injection_done_irq,
   input wire logic inj_read,
   input wire logic soft_inject,
   input wire logic trigger_compare_channel
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   chk_irq_gap_pulse: assert property (injection_done_irq |=> !injection_done_irq [*2])
      else $error("done irq not a lone pulse");
   chk_read_after_irq: assert property (injection_done_irq |-> ##2 inj_read)
      else $error("result not read two cycles after irq");
   chk_read_has_cause: assert property (inj_read |-> $past(injection_done_irq, 2))
      else $error("read without a preceding irq");
   chk_read_single: assert property (inj_read |=> !inj_read)
      else $error("read is not a single pulse");
   chk_result_moves: assert property ($changed(inj_data) |-> injection_done_irq)
      else $error("injected result changed without irq");
   chk_std_head_hold: assert property (std_valid && !std_ready |=> std_valid && $stable(std_data))
      else $error("standard head lost while not taken");
   chk_soft_pulse: assert property (soft_inject |=> !soft_inject)
      else $error("software request not a pulse");
   chk_cmp_pulse: assert property (trigger_compare_channel |=> !trigger_compare_channel)
      else $error("compare request not a pulse");
endmodule

// [dv/adc_channel_injection_control_test.sv]
// Bench joining converter and reader ends through one adcinj_if.
// Assumes the design sources compiled before it.
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("unexpected at %0t: %s", $time, msg); \
      end \
   end
module adc_channel_injection_control_test;
   import adcinj_pkg::*;
   typedef struct packed {
      logic [1:0] mode;
      logic cmp;
      logic [ADCINJ_CHAN_W-1:0] chan;
      logic [ADCINJ_DATA_W-1:0] smp;
   } adcinj_row_s;
   adcinj_row_s rows [4] = '{'{2'h0, 1'b0, 5'h03, 10'h155}, '{2'h1, 1'b1, 5'h1f, 10'h2aa},
      '{2'h2, 1'b0, 5'h00, 10'h3ff}, '{2'h3, 1'b1, 5'h10, 10'h001}};
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [1:0] mode_in = 2'h0;
   logic start_in = 1'b0;
   logic [ADCINJ_DATA_W-1:0] sample_in = 10'h000;
   logic soft_req_in = 1'b0;
   logic compare_evt_in = 1'b0;
   logic [ADCINJ_CHAN_W-1:0] channel_in = 5'h00;
   logic [ADCINJ_CHAN_W-1:0] std_channel_in = 5'h03;
   logic wait_read_en_in = 1'b1;
   logic std_take_in = 1'b1;
   logic busy_out, stalled_out, flag_out, inj_v, std_v;
   logic [ADCINJ_CHAN_W-1:0] conv_channel_out;
   logic [ADCINJ_DATA_W-1:0] inj_res, std_res;
   int n_mismatch = 0;
   int tests_run = 0;
   int n_inj = 0;
   int n_std = 0;

   adcinj_if lnk ();
   adcinj_dev u_adcinj_dev (.mclk_in(mclk_in), .rst_in(rst_in), .lnk(lnk), .mode_in(mode_in),
      .std_channel_in(std_channel_in), .start_in(start_in), .sample_in(sample_in),
      .busy_out(busy_out), .stalled_out(stalled_out), .injection_done_flag_out(flag_out),
      .conv_channel_out(conv_channel_out));
   adcinj_host u_adcinj_host (.mclk_in(mclk_in), .rst_in(rst_in), .lnk(lnk),
      .soft_req_in(soft_req_in), .compare_evt_in(compare_evt_in), .channel_in(channel_in),
      .wait_read_en_in(wait_read_en_in), .std_take_in(std_take_in), .inj_result_out(inj_res),
      .inj_result_valid_out(inj_v), .std_result_out(std_res), .std_result_valid_out(std_v));
   adcinj_sva u_adcinj_sva (.mclk_in(mclk_in), .rst_in(rst_in), .std_data(lnk.std_data),
      .std_valid(lnk.std_valid), .std_ready(lnk.std_ready), .inj_data(lnk.inj_data),
      .injection_done_irq(lnk.injection_done_irq), .inj_read(lnk.inj_read),
      .soft_inject(lnk.soft_inject), .trigger_compare_channel(lnk.trigger_compare_channel));

   initial begin
      forever #12.5 mclk_in = !mclk_in;
   end
   always @(negedge mclk_in) begin
      if (inj_v === 1'b1) n_inj++;
      if (std_v === 1'b1) n_std++;
   end

   // ==========
   // Helpers
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   function automatic logic sel(input int w);
      case (w)
         0: return inj_v;
         1: return stalled_out;
         2: return !lnk.std_valid;
         default: return !busy_out;
      endcase
   endfunction
   task automatic wait_for(input int w, input int lim);
      int k;
      k = 0;
      while (sel(w) !== 1'b1 && k < lim) begin
         @(negedge mclk_in);
         k++;
      end
      if (k == lim) begin
         n_mismatch++;
         $display("unexpected at %0t: wait %0d timed out", $time, w);
         test_done();
      end
   endtask
   task automatic trig(input logic cmp, input logic both);
      soft_req_in = !cmp || both;
      compare_evt_in = cmp;
      @(negedge mclk_in);
      soft_req_in = 1'b0;
      compare_evt_in = 1'b0;
   endtask

   // ==========
   // Sequence
   initial begin
      repeat (5) @(negedge mclk_in);
      rst_in = 1'b0;
      foreach (rows[i]) begin
         mode_in = rows[i].mode;
         std_channel_in = rows[i].chan ^ 5'h01;
         channel_in = rows[i].chan;
         sample_in = rows[i].smp;
         start_in = 1'b1;
         @(negedge mclk_in);
         start_in = 1'b0;
         trig(rows[i].cmp, 1'b0);
         wait_for(0, 400);
         `CHK(inj_res, rows[i].smp, "injected result")
         `CHK(flag_out, 1'b1, "done flag")
         n_std = 0;
         repeat (300) @(negedge mclk_in);
         `CHK(n_std > 0, rows[i].mode != 2'h0, "standard sequence after injection")
         `CHK(std_res, rows[i].smp, "standard result")
      end
      $display("rows done");
      std_take_in = 1'b0;
      mode_in = 2'h1;
      wait_for(1, 3000);
      `CHK(stalled_out, 1'b1, "full buffer stalls")
      n_inj = 0;
      trig(1'b1, 1'b0);
      repeat (300) @(negedge mclk_in);
      `CHK(n_inj, 0, "no injection while stalled")
      wait_read_en_in = 1'b0;
      @(negedge mclk_in);
      wait_read_en_in = 1'b1;
      repeat (3) @(negedge mclk_in);
      `CHK(stalled_out, 1'b0, "mode toggle releases stall")
      wait_for(0, 400);
      `CHK(inj_res, sample_in, "pending injection served")
      mode_in = 2'h0;
      n_std = 0;
      std_take_in = 1'b1;
      wait_for(2, 3000);
      `CHK(n_std >= 16, 1'b1, "buffer drained in full")
      $display("stall done");
      wait_for(3, 400);
      n_inj = 0;
      trig(1'b1, 1'b1);
      repeat (5) @(negedge mclk_in);
      `CHK(busy_out, 1'b1, "merged trigger starts an injection")
      `CHK(conv_channel_out, channel_in, "injection converts chosen channel")
      trig(1'b0, 1'b0);
      repeat (600) @(negedge mclk_in);
      `CHK(n_inj, 2, "merged then re-armed trigger")
      $display("merge done");
      trig(1'b0, 1'b0);
      repeat (50) @(negedge mclk_in);
      rst_in = 1'b1;
      @(negedge mclk_in);
      `CHK({busy_out, stalled_out, flag_out, inj_v}, 4'h0, "outputs cleared in reset")
      rst_in = 1'b0;
      trig(1'b0, 1'b0);
      wait_for(0, 400);
      `CHK(inj_res, sample_in, "injection after reset")
      $display("reset done");
      test_done();
   end
endmodule
